// file: tsit_pkg.sv
// constants, codes and state encoding for the two-stage input trigger
package tsit_pkg;

  // apb geometry
  localparam int             TSIT_ADDR_W      = 8;   // byte address width
  localparam int             TSIT_DATA_W      = 32;  // bus data width
  localparam int             TSIT_PORT_W      = 8;   // input port width
  localparam int             TSIT_FIELD_W     = 3;   // condition code width
  localparam int             TSIT_COMBINE_BIT = 31;  // and/or select bit
  localparam int             TSIT_IRQ_W       = 2;   // interrupt sources

  // register byte offsets
  localparam logic [7:0]     TSIT_OFS_CFG1    = 8'h00;  // first_stage_trigger_config
  localparam logic [7:0]     TSIT_OFS_CFG2    = 8'h04;  // second_stage_trigger_config
  localparam logic [7:0]     TSIT_OFS_CTRL    = 8'h08;  // enable and re-arm
  localparam logic [7:0]     TSIT_OFS_STAT    = 8'h0C;  // state and pin levels
  localparam logic [7:0]     TSIT_OFS_IRQSTS  = 8'h10;  // sticky events, write one clears
  localparam logic [7:0]     TSIT_OFS_IRQMSK  = 8'h14;  // interrupt mask

  // writable bits of a stage register, reserved 30..24 read zero
  localparam logic [31:0]    TSIT_CFG_MASK    = 32'h80FF_FFFF;
  localparam logic [31:0]    TSIT_CFG_RESET   = 32'h0000_0000;

  // control bits
  localparam int             TSIT_CTRL_EN     = 0;   // trigger enable
  localparam int             TSIT_CTRL_ARM    = 1;   // write one to re-arm

  // status layout
  localparam int             TSIT_STAT_LVL_LO = 8;   // pin levels at 15..8

  // interrupt bits
  localparam int             TSIT_IRQ_FIRST   = 0;   // first-stage event
  localparam int             TSIT_IRQ_START   = 1;   // sampling started

  // condition codes
  localparam logic [2:0]     TSIT_CODE_NONE   = 3'h0;
  localparam logic [2:0]     TSIT_CODE_RISE   = 3'h1;
  localparam logic [2:0]     TSIT_CODE_FALL   = 3'h2;
  localparam logic [2:0]     TSIT_CODE_EDGE   = 3'h3;
  localparam logic [2:0]     TSIT_CODE_HIGH   = 3'h4;
  localparam logic [2:0]     TSIT_CODE_LOW    = 3'h5;
  localparam logic [2:0]     TSIT_CODE_ALW6   = 3'h6;
  localparam logic [2:0]     TSIT_CODE_ALW7   = 3'h7;

  // timing
  localparam int             TSIT_CLK_NS      = 40;  // 25 mhz clock period
  localparam int             TSIT_GAP_NS      = 60;  // least stage-to-stage gap
  localparam int             TSIT_GAP_CYC     = (TSIT_GAP_NS + TSIT_CLK_NS - 1) / TSIT_CLK_NS;

  // one-hot trigger states
  typedef enum logic [3:0] {
    TSIT_DISARMED    = 4'h1,
    TSIT_WAIT_FIRST  = 4'h2,
    TSIT_WAIT_SECOND = 4'h4,
    TSIT_SAMPLING    = 4'h8
  } tsit_state_type;

endpackage

// file: tsit_eval_if.sv
// bundle between the controller and one stage condition evaluator
`timescale 1ns/1ps
interface tsit_eval_if;
  logic [31:0] cfg;   // stage register
  logic [7:0]  lvl;   // synchronised pin levels
  logic [7:0]  prev;  // levels one cycle earlier
  logic [7:0]  cond;  // per-bit condition results
  logic        hit;   // combined stage event
  modport eval (input cfg, input lvl, input prev, output cond, output hit);
  modport user (output cfg, output lvl, output prev, input cond, input hit);
endinterface

// file: tsit_cond_eval.sv
// per-bit condition decode and and/or combine for one trigger stage
`timescale 1ns/1ps
module tsit_cond_eval
  import tsit_pkg::*;
(
  tsit_eval_if.eval ev
);

  logic comb_and;  // combine select

  assign comb_and = ev.cfg[TSIT_COMBINE_BIT];

  // one decoder per input bit, field n sits at 3n
  for (genvar n = 0; n < TSIT_PORT_W; n++) begin : g_bit
    logic [2:0] code;  // this bit's code
    assign code = ev.cfg[TSIT_FIELD_W*n +: TSIT_FIELD_W];
    always_comb begin
      case (code)
        TSIT_CODE_NONE: ev.cond[n] = comb_and;
        TSIT_CODE_RISE: ev.cond[n] = ev.lvl[n] & ~ev.prev[n];
        TSIT_CODE_FALL: ev.cond[n] = ~ev.lvl[n] & ev.prev[n];
        TSIT_CODE_EDGE: ev.cond[n] = ev.lvl[n] ^ ev.prev[n];
        TSIT_CODE_HIGH: ev.cond[n] = ev.lvl[n];
        TSIT_CODE_LOW:  ev.cond[n] = ~ev.lvl[n];
        default:        ev.cond[n] = 1'b1;
      endcase
    end
  end

  // and needs every condition at once, or needs any one
  assign ev.hit = comb_and ? (&ev.cond) : (|ev.cond);

endmodule

// file: tsit_trigger.sv
// two-stage input trigger controller with apb registers and interrupt
`timescale 1ns/1ps
module tsit_trigger
  import tsit_pkg::*;
(
  input  wire logic        mclk_i,     // 25 mhz clock
  input  wire logic        rst_b_i,    // async reset, active low
  input  wire logic        ce_i,       // clock enable, freezes state
  input  wire logic [7:0]  din_i,      // input port pins, asynchronous
  input  wire logic        psel_i,     // apb select
  input  wire logic        penable_i,  // apb access phase
  input  wire logic        pwrite_i,   // apb direction
  input  wire logic [7:0]  paddr_i,    // apb byte address
  input  wire logic [31:0] pwdata_i,   // apb write data
  output logic      [31:0] prdata_o,   // apb read data
  output logic             pready_o,   // apb ready
  output logic             pslverr_o,  // apb error, unmapped address
  output logic             sampling_o, // periodic sampling running
  output logic             start_o,    // one-cycle pulse at sampling start
  output logic             irq_o       // level interrupt
);

  // all state of the controller
  typedef struct packed {
    logic [7:0]     sync1;    // first synchroniser stage
    logic [7:0]     sync2;    // second synchroniser stage
    logic [7:0]     prev;     // previous synchronised levels
    logic [31:0]    cfg1;     // first_stage_trigger_config
    logic [31:0]    cfg2;     // second_stage_trigger_config
    logic           enable;   // trigger enabled
    tsit_state_type state;    // trigger sequence state
    logic           start;    // start pulse
    logic [1:0]     irq_sts;  // sticky events
    logic [1:0]     irq_msk;  // interrupt mask
    logic [31:0]    prdata;   // read data
    logic           pslverr;  // error answer
    logic           rd_valid; // read data held for the transfer in flight
  } tsit_regs_type;

  tsit_regs_type q;          // registered state
  tsit_regs_type d;          // next state

  tsit_eval_if   ev1 ();     // first-stage evaluator bundle
  tsit_eval_if   ev2 ();     // second-stage evaluator bundle

  logic          setup;      // apb setup phase
  logic          wr;         // apb write taking effect
  logic          mapped;     // address decodes to a register
  logic          cfg_wr;     // write to either stage register
  logic          rearm;      // return to waiting for first stage
  logic [1:0]    irq_set;    // events this cycle
  logic [31:0]   stat_word;  // status read value

  // first stage reads its own register
  assign ev1.cfg  = q.cfg1;
  assign ev1.lvl  = q.sync2;
  assign ev1.prev = q.prev;

  // second stage has a register of its own
  assign ev2.cfg  = q.cfg2;
  assign ev2.lvl  = q.sync2;
  assign ev2.prev = q.prev;

  // first-stage evaluator
  tsit_cond_eval u_eval1 (
    .ev (ev1)
  );

  // second-stage evaluator
  tsit_cond_eval u_eval2 (
    .ev (ev2)
  );

  // bus phase decode, frozen while clock enable is low; read data are
  // captured by the first enabled cycle of a transfer and ready waits
  // for them, so a setup edge lost to a low enable costs one wait state
  assign setup    = ce_i & psel_i & ~q.rd_valid;
  assign wr       = ce_i & psel_i & penable_i & pwrite_i & q.rd_valid;
  assign pready_o = ce_i & q.rd_valid;

  // address decode
  always_comb begin
    case (paddr_i)
      TSIT_OFS_CFG1, TSIT_OFS_CFG2, TSIT_OFS_CTRL,
      TSIT_OFS_STAT, TSIT_OFS_IRQSTS, TSIT_OFS_IRQMSK: mapped = 1'b1;
      default:                                        mapped = 1'b0;
    endcase
  end

  // status word: state code and pin levels
  always_comb begin
    stat_word = '0;
    stat_word[3:0] = q.state;
    stat_word[TSIT_STAT_LVL_LO +: TSIT_PORT_W] = q.sync2;
  end

  // writes to stage registers or the arm bit restart the sequence
  assign cfg_wr = wr & ((paddr_i == TSIT_OFS_CFG1) | (paddr_i == TSIT_OFS_CFG2));
  assign rearm  = cfg_wr |
                  (wr & (paddr_i == TSIT_OFS_CTRL) & pwdata_i[TSIT_CTRL_ARM]);

  // next-state logic
  always_comb begin
    d       = q;
    irq_set = '0;
    if (ce_i) begin
      // pins pass two flops before any logic sees them
      d.sync1 = din_i;
      d.sync2 = q.sync1;
      d.prev  = q.sync2;
      d.start = 1'b0;

      // read data captured in setup so it is a flop at access
      if (setup) begin
        d.rd_valid = 1'b1;   // ready in the next cycle
        d.pslverr  = ~mapped;
        case (paddr_i)
          TSIT_OFS_CFG1:   d.prdata = q.cfg1;
          TSIT_OFS_CFG2:   d.prdata = q.cfg2;
          TSIT_OFS_CTRL:   d.prdata = {31'h0000_0000, q.enable};
          TSIT_OFS_STAT:   d.prdata = stat_word;
          TSIT_OFS_IRQSTS: d.prdata = {30'h0000_0000, q.irq_sts};
          TSIT_OFS_IRQMSK: d.prdata = {30'h0000_0000, q.irq_msk};
          default:         d.prdata = '0;
        endcase
      end else if (!psel_i || penable_i) begin
        // access ends or bus idle, the next setup captures afresh
        d.rd_valid = 1'b0;
      end

      // register writes
      if (wr) begin
        case (paddr_i)
          TSIT_OFS_CFG1:   d.cfg1    = pwdata_i & TSIT_CFG_MASK;
          TSIT_OFS_CFG2:   d.cfg2    = pwdata_i & TSIT_CFG_MASK;
          TSIT_OFS_CTRL:   d.enable  = pwdata_i[TSIT_CTRL_EN];
          TSIT_OFS_IRQMSK: d.irq_msk = pwdata_i[1:0];
          default:         d.enable  = q.enable;
        endcase
      end

      // trigger sequence; a clear of enable wins over an arm bit
      // written with it, and any stage register write re-arms
      if (!d.enable) begin
        d.state = TSIT_DISARMED;
      end else if (rearm || q.state == TSIT_DISARMED) begin
        d.state = TSIT_WAIT_FIRST;
      end else begin
        case (q.state)
          // only the first stage is looked at here
          TSIT_WAIT_FIRST: begin
            if (ev1.hit) begin
              d.state = TSIT_WAIT_SECOND;
              irq_set[TSIT_IRQ_FIRST] = 1'b1;
            end
          end
          // second stage evaluated from the next cycle on
          TSIT_WAIT_SECOND: begin
            if (ev2.hit) begin
              d.state = TSIT_SAMPLING;
              d.start = 1'b1;
              irq_set[TSIT_IRQ_START] = 1'b1;
            end
          end
          // held until re-armed, reconfigured or disabled
          TSIT_SAMPLING:   d.state = TSIT_SAMPLING;
          default:         d.state = TSIT_DISARMED;
        endcase
      end

      // sticky status, a new event wins over a clear
      if (wr && paddr_i == TSIT_OFS_IRQSTS) begin
        d.irq_sts = (q.irq_sts & ~pwdata_i[1:0]) | irq_set;
      end else begin
        d.irq_sts = q.irq_sts | irq_set;
      end
    end
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{sync1: '0, sync2: '0, prev: '0,
             cfg1: TSIT_CFG_RESET, cfg2: TSIT_CFG_RESET,
             enable: 1'b0, state: TSIT_DISARMED, start: 1'b0,
             irq_sts: '0, irq_msk: '0, prdata: '0, pslverr: 1'b0,
             rd_valid: 1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs
  assign prdata_o   = q.prdata;
  assign pslverr_o  = q.pslverr;
  assign sampling_o = (q.state == TSIT_SAMPLING);
  assign start_o    = q.start;
  assign irq_o      = |(q.irq_sts & q.irq_msk);

  // checks on the trigger sequence, the pins and the bus

  // start pulse only after the second stage was being waited on
  chk_start_order: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(start_o) |-> $past(q.state) == TSIT_WAIT_SECOND && $past(ev2.hit))
    else $error("sampling started out of order");

  // a second-stage event two cycles after the first starts sampling
  chk_short_gap: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && q.state == TSIT_WAIT_FIRST && ev1.hit && q.enable && !rearm && !wr) ##1
    (ce_i && !ev2.hit && !wr) ##1
    (ce_i && ev2.hit && !wr) |=> start_o && sampling_o)
    else $error("second stage after short gap missed");

  // second stage activity before the first stage is ignored
  chk_stage2_gated: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && q.state == TSIT_WAIT_FIRST && !ev1.hit && ev2.hit && !wr)
    |=> q.state == TSIT_WAIT_FIRST && !start_o)
    else $error("second stage evaluated too early");

  // and mode holds while not every condition is true
  chk_first_and: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && q.state == TSIT_WAIT_FIRST && q.cfg1[TSIT_COMBINE_BIT] && !(&ev1.cond) && !wr)
    |=> q.state == TSIT_WAIT_FIRST)
    else $error("and-combined first stage fired early");

  // or mode fires on any single condition
  chk_first_or: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && q.state == TSIT_WAIT_FIRST && !q.cfg1[TSIT_COMBINE_BIT] && (|ev1.cond) && !wr)
    |=> q.state == TSIT_WAIT_SECOND && q.irq_sts[TSIT_IRQ_FIRST])
    else $error("or-combined first stage missed");

  // second stage and mode with all conditions starts sampling
  chk_second_and: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && q.state == TSIT_WAIT_SECOND && q.cfg2[TSIT_COMBINE_BIT] && (&ev2.cond) && !wr)
    |=> q.state == TSIT_SAMPLING)
    else $error("and-combined second stage missed");

  // field of bit 7 decodes the high-level code
  chk_field_map: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    q.cfg2[23:21] == TSIT_CODE_HIGH |-> ev2.cond[7] == q.sync2[7])
    else $error("bit 7 field misplaced");

  // always codes and code zero under and mode are true
  chk_code_always: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (q.cfg2[2:1] == 2'h3 || (q.cfg2[2:0] == TSIT_CODE_NONE && q.cfg2[TSIT_COMBINE_BIT]))
    |-> ev2.cond[0])
    else $error("always code not true");

  // rising edge code on bit 0
  chk_edge_rise: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    q.cfg2[2:0] == TSIT_CODE_RISE |-> ev2.cond[0] == (q.sync2[0] && !q.prev[0]))
    else $error("rising edge decode wrong");

  // low-level code on bit 1
  chk_level_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    q.cfg1[5:3] == TSIT_CODE_LOW |-> ev1.cond[1] == !q.sync2[1])
    else $error("low level decode wrong");

  // evaluated levels are the pins two enabled edges back
  chk_pin_sync: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $past(rst_b_i, 2) && $past(rst_b_i, 1) && $past(ce_i, 1) && $past(ce_i, 2)
    |-> q.sync2 == $past(din_i, 2))
    else $error("pin levels not synchronised");

  // sampling holds without re-arm
  chk_sampling_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (q.state == TSIT_SAMPLING && !rearm && d.enable) |=> sampling_o)
    else $error("sampling dropped without re-arm");

  // second stage in any-condition mode fires on one condition
  chk_second_or: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && q.state == TSIT_WAIT_SECOND && !q.cfg2[TSIT_COMBINE_BIT] && (|ev2.cond) && !wr)
    |=> start_o && sampling_o && q.irq_sts[TSIT_IRQ_START])
    else $error("or-combined second stage missed");

  // second stage in all-conditions mode waits while one is missing
  chk_second_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && q.state == TSIT_WAIT_SECOND && q.cfg2[TSIT_COMBINE_BIT] && !(&ev2.cond) && !wr)
    |=> q.state == TSIT_WAIT_SECOND && !start_o)
    else $error("and-combined second stage fired early");

  // re-arm or reconfigure while enabled returns to the first stage
  chk_rearm_wait: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && rearm && d.enable)
    |=> q.state == TSIT_WAIT_FIRST && !sampling_o)
    else $error("re-arm did not return to first stage");

  // enable cleared leaves the sequence disarmed
  chk_disarm_state: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && !d.enable)
    |=> q.state == TSIT_DISARMED && !sampling_o)
    else $error("disabled trigger not disarmed");

  // one start pulse per entry into sampling
  chk_start_once: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (sampling_o && $past(sampling_o) && $past(ce_i)) |-> !start_o)
    else $error("repeated start pulse");

  // clock enable low freezes every flop
  chk_ce_freeze: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !ce_i |=> $stable(q))
    else $error("state moved while clock enable low");

  // a start event keeps its status bit even against a clear
  chk_irq_set_wins: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (ce_i && irq_set[TSIT_IRQ_START]) |=> q.irq_sts[TSIT_IRQ_START])
    else $error("start event lost by status clear");

  // a first stage register read answers with the register value of its own setup
  chk_read_answer: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (psel_i && penable_i && pready_o && !pwrite_i && paddr_i == TSIT_OFS_CFG1)
    |-> prdata_o == q.cfg1)
    else $error("read data not the register value");

  // an unmapped address answers with an error and zero data
  chk_unmapped_err: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (psel_i && penable_i && pready_o && !mapped)
    |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");

  // the second stage register keeps its own writable bits
  chk_cfg2_write: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (wr && paddr_i == TSIT_OFS_CFG2)
    |=> q.cfg2 == ($past(pwdata_i) & TSIT_CFG_MASK))
    else $error("second stage register write lost");

  // reserved bits of both stage registers stay zero
  chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (q.cfg1[30:24] == 7'h00) && (q.cfg2[30:24] == 7'h00))
    else $error("reserved stage bits set");

  // main scenarios
  cov_first_event:  cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    q.state == TSIT_WAIT_FIRST ##1 q.state == TSIT_WAIT_SECOND);
  cov_start:        cover property (@(posedge mclk_i) disable iff (!rst_b_i) start_o);
  cov_and_start:    cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    start_o && q.cfg2[TSIT_COMBINE_BIT]);
  cov_irq:          cover property (@(posedge mclk_i) disable iff (!rst_b_i) irq_o);
  // sequence resumes after a frozen stretch
  cov_freeze:       cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    !ce_i ##1 ce_i);

endmodule

// file: tsit_pin_model.sv
// input port pin model with a prompt or a slow response
`timescale 1ns/1ps
module tsit_pin_model (
  input  wire logic       mclk_i,  // bench clock
  input  wire logic [7:0] want_i,  // requested pin levels
  input  wire logic       slow_i,  // one extra cycle of delay
  output logic      [7:0] din_o    // levels at the connector
);
  logic [7:0] stage_q;  // first delay stage

  // real pin levels, same delay for every pin keeps event spacing
  always_ff @(posedge mclk_i) begin
    stage_q <= want_i;
    din_o   <= slow_i ? stage_q : want_i;
  end
endmodule

// file: two_stage_input_trigger_test.sv
// self-checking bench for the two-stage input trigger
`timescale 1ns/1ps
module two_stage_input_trigger_test;
  import tsit_pkg::*;
  logic        mclk_i = 1'b0;   // bench clock
  logic        rst_b_i;         // reset, active low
  logic [7:0]  want;            // pin levels asked of the model
  logic        slow;            // model delay select
  logic        ce;              // clock enable into the design
  logic [7:0]  din;             // pins into the design
  logic        psel;            // apb select
  logic        penable;         // apb access phase
  logic        pwrite;          // apb direction
  logic [7:0]  paddr;           // apb address
  logic [31:0] pwdata;          // apb write data
  logic [31:0] prdata;          // apb read data
  logic        pready;          // apb ready
  logic        pslverr;         // apb error
  logic        sampling;        // sampling running
  logic        start;           // start pulse
  logic        irq;             // interrupt
  logic [31:0] rq;              // last read data
  logic        re;              // last error flag
  logic [31:0] starts = 32'h0;  // start pulses seen
  int          mismatches = 0;  // failed checks
  int          n_tests = 0;     // checks made
  // pin code nibbles: code, level before, level after, event expected
  localparam logic [15:0] CODE_TAB [13] = '{16'h0010, 16'h1011, 16'h1100,
    16'h2101, 16'h2010, 16'h3101, 16'h3011, 16'h4011, 16'h4000, 16'h5110,
    16'h5101, 16'h6001, 16'h7111};

  tsit_trigger tsit_trigger_i (
    .mclk_i     (mclk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce),
    .din_i      (din),
    .psel_i     (psel),
    .penable_i  (penable),
    .pwrite_i   (pwrite),
    .paddr_i    (paddr),
    .pwdata_i   (pwdata),
    .prdata_o   (prdata),
    .pready_o   (pready),
    .pslverr_o  (pslverr),
    .sampling_o (sampling),
    .start_o    (start),
    .irq_o      (irq)
  );

  tsit_pin_model tsit_pin_model_i (
    .mclk_i (mclk_i),
    .want_i (want),
    .slow_i (slow),
    .din_o  (din)
  );

  // 25 mhz clock
  always #20 mclk_i = ~mclk_i;

  // count start pulses, one per cycle high
  always @(posedge mclk_i) begin
    if (start === 1'b1) begin
      starts <= starts + 32'h1;
    end
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h", $time, m, got);
    end
  endtask

  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) begin
      @(posedge mclk_i);
    end
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rq, exp, m);
  endtask

  // state field of the status register only
  task automatic rd_st(input logic [31:0] exp, input string m);
    apb(1'b0, TSIT_OFS_STAT, 32'h0);
    chk(rq & 32'h0000_000F, exp, m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic pins(input logic [7:0] v);
    @(posedge mclk_i);
    want <= v;
  endtask

  // reset values, reserved bits, unmapped address
  task automatic t_reset;
    rd(TSIT_OFS_CFG1, TSIT_CFG_RESET, "cfg1 reset");
    rd_st(32'h1, "disarmed at reset");
    rd(TSIT_OFS_IRQSTS, 32'h0, "irq reset");
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, re}, 32'h1, "unmapped error");
    wr(TSIT_OFS_CFG1, 32'hFFFF_FFFF);
    rd(TSIT_OFS_CFG1, TSIT_CFG_MASK, "cfg1 reserved");
    wr(TSIT_OFS_CFG2, 32'hFFFF_FFFF);
    rd(TSIT_OFS_CFG2, TSIT_CFG_MASK, "cfg2 reserved");
    $display("test reset done");
  endtask

  // pin7 fall then pin0 rise two cycles later, interrupt, re-arm
  task automatic t_order;
    wr(TSIT_OFS_CFG1, 32'h0040_0000);
    wr(TSIT_OFS_CFG2, 32'h0000_0001);
    pins(8'h80);
    cyc(4);
    wr(TSIT_OFS_CTRL, 32'h0000_0001);
    rd_st(32'h2, "armed");
    pins(8'h81);
    cyc(4);
    pins(8'h80);
    cyc(4);
    rd_st(32'h2, "second stage early");
    chk(starts, 32'h0, "no early start");
    pins(8'h00);
    cyc(1);
    pins(8'h01);
    cyc(8);
    rd(TSIT_OFS_STAT, 32'h0000_0108, "sampling and pins");
    chk(starts, 32'h1, "one start pulse");
    pins(8'h00);
    cyc(4);
    pins(8'h01);
    cyc(4);
    rd_st(32'h8, "sampling holds");
    chk(starts, 32'h1, "no second start");
    rd(TSIT_OFS_IRQSTS, 32'h3, "both events latched");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(TSIT_OFS_IRQMSK, 32'h2);
    cyc(1);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(TSIT_OFS_IRQSTS, 32'h3);
    rd(TSIT_OFS_IRQSTS, 32'h0, "irq cleared");
    chk({31'h0, irq}, 32'h0, "irq low after clear");
    wr(TSIT_OFS_CTRL, 32'h0000_0003);
    rd_st(32'h2, "re-armed");
    chk({31'h0, sampling}, 32'h0, "sampling stopped");
    $display("test order done");
  endtask

  // all-conditions mode on both stages
  task automatic t_and;
    pins(8'h03);
    cyc(4);
    wr(TSIT_OFS_CFG1, 32'h8000_002C);
    cyc(4);
    rd_st(32'h2, "and one short");
    pins(8'h01);
    cyc(6);
    rd_st(32'h4, "and all met");
    wr(TSIT_OFS_CFG2, 32'h8080_0000);
    cyc(6);
    rd_st(32'h4, "second and short");
    pins(8'h81);
    cyc(6);
    rd_st(32'h8, "second and met");
    $display("test and done");
  endtask

  // every condition code on pin 3 in any-condition mode, slow pins
  task automatic t_codes;
    logic [15:0] t;
    wr(TSIT_OFS_CFG2, 32'h0000_0000);
    slow <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      t = CODE_TAB[i];
      pins({4'h0, t[8], 3'h0});
      cyc(4);
      wr(TSIT_OFS_CFG1, {20'h0, t[14:12], 9'h0});
      cyc(4);
      pins({4'h0, t[4], 3'h0});
      cyc(6);
      rd_st(t[0] ? 32'h4 : 32'h2, "code table");
    end
    $display("test codes done");
  endtask

  // clock enable low freezes the sequence, pins seen once it returns
  task automatic t_freeze;
    slow <= 1'b0;
    wr(TSIT_OFS_IRQMSK, 32'h1);
    wr(TSIT_OFS_CFG1, 32'h0000_0004);
    cyc(6);
    wr(TSIT_OFS_IRQSTS, 32'h3);
    rd_st(32'h2, "armed before freeze");
    @(posedge mclk_i);
    ce <= 1'b0;
    pins(8'h09);
    cyc(8);
    chk({31'h0, irq}, 32'h0, "frozen, no event");
    ce <= 1'b1;
    cyc(6);
    chk({31'h0, irq}, 32'h1, "event after freeze");
    rd_st(32'h4, "first stage after freeze");
    $display("test freeze done");
  endtask

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200_000;
    mismatches++;
    stop_test;
  end

  // main sequence
  initial begin
    rst_b_i = 1'b0;
    want    = 8'h00;
    slow    = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_order;
    t_and;
    t_codes;
    t_freeze;
    stop_test;
  end
endmodule
